// >>> src/pfag_access.sv
// Write qualification and data-line drive decision for the host bus
`timescale 1ns/1ns
module pfag_access
  import pfag_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  pfag_bus_if.qual bus
);
  logic sel_q;
  logic wr_ff;
  logic nxt_wr;
  logic rd_ok_ff;
  logic nxt_rd_ok;
  logic sel_d_ff;
  logic nxt_sel_d;

  assign sel_q = bus.sel & ~bus.block;

  always_comb begin
    nxt_wr = sel_q & bus.wr; // RULE1
    nxt_sel_d = sel_q;
    nxt_rd_ok = rd_ok_ff;
    // A select that arrives with or after the write strobe never drives
    if (sel_q & ~sel_d_ff) begin
      nxt_rd_ok = ~bus.wr; // RULE3
    end else if (~sel_q) begin
      nxt_rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ff <= 1'b0;
      rd_ok_ff <= 1'b0;
      sel_d_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ok_ff <= nxt_rd_ok;
      sel_d_ff <= nxt_sel_d;
    end
  end

  assign bus.wr_active = wr_ff;
  assign bus.wr_start = nxt_wr & ~wr_ff; // RULE1
  assign bus.wr_end = wr_ff & ~nxt_wr; // RULE2
  // Output enable high or a write in progress keeps the lines floating
  assign bus.drive = rd_ok_ff & sel_q & ~bus.wr & bus.oe; // RULE3 RULE6
endmodule

// >>> src/pfag_bus_if.sv
// Bundle carrying the host strobes from the top to the access qualifier
`timescale 1ns/1ns
interface pfag_bus_if;
  logic sel;
  logic wr;
  logic oe;
  logic block;
  logic wr_active;
  logic wr_start;
  logic wr_end;
  logic drive;
  modport top (output sel, output wr, output oe, output block, input wr_active, input wr_start, input wr_end,
    input drive);
  modport qual (input sel, input wr, input oe, input block, output wr_active, output wr_start, output wr_end,
    output drive);
endinterface

// >>> src/pfag_pkg.sv
// Package for the power-fail access guard: timing constants and states
package pfag_pkg;
  localparam int CLK_MHZ = 100;
  // Figures as printed, in their own units
  localparam int FAIL_IRQ_MIN_US = 6;
  localparam int FAIL_IRQ_MAX_US = 24;
  localparam int RAM_PROTECT_MIN_US = 90;
  localparam int RAM_PROTECT_MAX_US = 125;
  localparam int RECOVERY_MIN_MS = 100;
  localparam int RECOVERY_MAX_MS = 300;
  // Aim at the middle of each window; typical values where printed
  localparam int FAIL_IRQ_US = (FAIL_IRQ_MIN_US + FAIL_IRQ_MAX_US) / 2;
  localparam int RAM_PROTECT_US = 100;
  localparam int RECOVERY_MS = 200;
  localparam int US_CYCLES = CLK_MHZ;
  localparam int FAIL_IRQ_CYCLES = FAIL_IRQ_US * US_CYCLES;
  localparam int RAM_PROTECT_CYCLES = RAM_PROTECT_US * US_CYCLES;
  localparam int RECOVERY_CYCLES = RECOVERY_MS * 1000 * US_CYCLES;
  localparam int CNT_W = 25;
  localparam logic RST_STATE_FAIL = 1'b1;

  typedef enum logic [1:0] {
    PFAG_POWERED = 2'b00,
    PFAG_FAILING = 2'b01,
    PFAG_DOWN = 2'b10,
    PFAG_RECOVER = 2'b11
  } pfag_state_t;
endpackage

// >>> src/pfag_top.sv
// Power-fail access guard: host strobe gating and supply-loss sequencing
// Notes on behaviour
// RULE1 - A write is accepted only during select and write overlap, starting at later fall.
// RULE2 - A write ends at the earlier rise of select or write strobe.
// RULE3 - Select falling with or after write strobe keeps data lines floating.
// RULE4 - Host holds write strobe high throughout every read.
// RULE5 - Host holds select or write high while address changes.
// RULE6 - Output enable high keeps data lines floating, even when writing.
// RULE7 - Interrupt asserts 6 to 24 microseconds after supply fails; a failure during the recovery hold-off asserts it two cycles after detection.
// RULE8 - RAM protect and processor reset assert 90 to 125 microseconds after failure.
// RULE9 - Select is ignored for 100 to 300 milliseconds after supply returns.
// RULE10 - Processor reset held until that power-up period ends.
// RULE11 - RAM stays protected for the same recovery period.
// RULE12 - RAM enable passes through unless protected, then forced inactive.
// RULE13 - All intervals come from the fixed time base counter.
`timescale 1ns/1ns
module pfag_top
  import pfag_pkg::*;
#(
  parameter int RECOVERY_LEN = RECOVERY_CYCLES
)(
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic POWER_FAIL_I,
  input wire logic SEL_N_I,
  input wire logic WR_N_I,
  input wire logic OE_N_I,
  input wire logic RAM_EN_N_I,
  input wire logic [7:0] DATA_I,
  input wire logic [7:0] RD_DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE_N_O,
  output logic [7:0] WR_DATA_O,
  output logic WR_STROBE_O,
  output logic WR_ACTIVE_O,
  output logic RAM_EN_N_O,
  output logic FAIL_IRQ_N_O,
  output logic FAIL_IRQ_OE_N_O,
  output logic CPU_RST_N_O,
  output logic CPU_RST_OE_N_O,
  output logic SEL_BLOCKED_O
);
  pfag_bus_if bus ();

  // Two-stage synchronisers for every input pin except RD_DATA_I (registered once) and the reset
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] nxt_sync1;
  logic [4:0] nxt_sync2;
  logic [7:0] din1_ff;
  logic [7:0] din2_ff;
  logic [7:0] nxt_din1;
  logic [7:0] nxt_din2;
  logic pf_s;

  always_comb begin
    nxt_sync1 = {POWER_FAIL_I, SEL_N_I, WR_N_I, OE_N_I, RAM_EN_N_I};
    nxt_sync2 = sync1_ff;
    nxt_din1 = DATA_I;
    nxt_din2 = din1_ff;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      // Idle pin levels, so no false supply failure follows reset
      sync1_ff <= 5'h0F;
      sync2_ff <= 5'h0F;
      din1_ff <= 8'h00;
      din2_ff <= 8'h00;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      din1_ff <= nxt_din1;
      din2_ff <= nxt_din2;
    end
  end

  assign pf_s = sync2_ff[4];

  // Supply sequencer
  pfag_state_t state_ff;
  pfag_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic irq_ff;
  logic nxt_irq;
  logic protect_ff;
  logic nxt_protect;

  function automatic logic reached(input logic [CNT_W-1:0] c, input int lim);
    reached = ({7'h00, c} >= lim[31:0] - 32'h1);
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 25'h1; // RULE13
    nxt_irq = irq_ff;
    nxt_protect = protect_ff;
    case (state_ff)
      PFAG_POWERED: begin
        nxt_cnt = '0;
        nxt_protect = 1'b0;
        nxt_irq = 1'b0;
        if (pf_s) begin
          nxt_state = PFAG_FAILING;
        end
      end
      PFAG_FAILING: begin
        if (!pf_s) begin
          // Glitch shorter than the protect delay; a dip during recovery restarts the hold-off
          nxt_state = protect_ff ? PFAG_RECOVER : PFAG_POWERED;
          nxt_cnt = '0;
          nxt_irq = 1'b0;
        end else begin
          if (reached(cnt_ff, FAIL_IRQ_CYCLES)) begin
            nxt_irq = 1'b1; // RULE7
          end
          if (reached(cnt_ff, RAM_PROTECT_CYCLES)) begin
            nxt_protect = 1'b1; // RULE8
            nxt_state = PFAG_DOWN;
            nxt_cnt = '0;
          end
        end
      end
      PFAG_DOWN: begin
        nxt_cnt = '0;
        if (!pf_s) begin
          nxt_state = PFAG_RECOVER;
          nxt_irq = 1'b0;
        end
      end
      PFAG_RECOVER: begin
        if (pf_s) begin
          nxt_state = PFAG_FAILING;
          nxt_cnt = 25'(RAM_PROTECT_CYCLES);
        end else if (reached(cnt_ff, RECOVERY_LEN)) begin
          nxt_state = PFAG_POWERED; // RULE9 RULE10 RULE11
          nxt_protect = 1'b0;
          nxt_cnt = '0;
        end
      end
      default: begin
        nxt_state = PFAG_DOWN;
        nxt_protect = 1'b1;
      end
    endcase
  end

  // Reset assumes the supply was just restored: full recovery hold-off
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state_ff <= PFAG_RECOVER;
      cnt_ff <= '0;
      irq_ff <= 1'b0;
      protect_ff <= RST_STATE_FAIL;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      irq_ff <= nxt_irq;
      protect_ff <= nxt_protect;
    end
  end

  // Host access qualification
  assign bus.sel = ~sync2_ff[3];
  assign bus.wr = ~sync2_ff[2];
  assign bus.oe = ~sync2_ff[1];
  assign bus.block = protect_ff; // RULE9

  pfag_access u_access (
    .clk_i(CLK_SYS_I),
    .srst_i(SRST_I),
    .bus(bus)
  );

  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic strobe_ff;
  logic nxt_strobe;
  logic ram_n_ff;
  logic nxt_ram_n;
  logic oe_n_ff;
  logic nxt_oe_n;

  always_comb begin
    // Data latched while the write is open; presented at its end
    nxt_wdata = bus.wr_active ? din2_ff : wdata_ff;
    nxt_strobe = bus.wr_end; // RULE2
    nxt_rdata = RD_DATA_I;
    nxt_oe_n = ~bus.drive; // RULE6
    nxt_ram_n = protect_ff ? 1'b1 : sync2_ff[0]; // RULE12 RULE11 RULE8
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
      strobe_ff <= 1'b0;
      ram_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else begin
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      strobe_ff <= nxt_strobe;
      ram_n_ff <= nxt_ram_n;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign DATA_O = rdata_ff;
  assign DATA_OE_N_O = oe_n_ff;
  assign WR_DATA_O = wdata_ff;
  assign WR_STROBE_O = strobe_ff;
  assign WR_ACTIVE_O = bus.wr_active;
  assign RAM_EN_N_O = ram_n_ff;
  // Open-drain: pin pulled low when enable is low
  assign FAIL_IRQ_N_O = 1'b0;
  assign FAIL_IRQ_OE_N_O = ~irq_ff; // RULE7
  assign CPU_RST_N_O = 1'b0;
  assign CPU_RST_OE_N_O = ~protect_ff; // RULE8 RULE10
  assign SEL_BLOCKED_O = protect_ff;
endmodule

// >>> test/pfag_assertions.sv
// Pin-level timing checks for the power-fail access guard
`timescale 1ns/1ns
module pfag_assertions #(parameter int RECOVERY_LEN = 50) (
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic POWER_FAIL_I,
  input wire logic SEL_N_I,
  input wire logic WR_N_I,
  input wire logic OE_N_I,
  input wire logic DATA_OE_N_O,
  input wire logic WR_ACTIVE_O,
  input wire logic RAM_EN_N_O,
  input wire logic FAIL_IRQ_OE_N_O,
  input wire logic CPU_RST_OE_N_O,
  input wire logic SEL_BLOCKED_O
);
  // Cycles in failure, and since supply or reset came good
  int fcnt_ff;
  int ocnt_ff;
  int nxt_fcnt;
  int nxt_ocnt;
  always_comb begin
    nxt_fcnt = POWER_FAIL_I ? fcnt_ff + 1 : 0;
    nxt_ocnt = (SRST_I || POWER_FAIL_I) ? 0 : ocnt_ff + 1;
  end
  always_ff @(posedge CLK_SYS_I) begin
    fcnt_ff <= nxt_fcnt;
    ocnt_ff <= nxt_ocnt;
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  property p_won; (!SEL_N_I && !WR_N_I && !SEL_BLOCKED_O) [*5] |-> WR_ACTIVE_O; endproperty
  a_won: assert property (p_won) else $error("write not opened");
  property p_woff; (SEL_N_I || WR_N_I) [*4] |-> !WR_ACTIVE_O; endproperty
  a_woff: assert property (p_woff) else $error("write not closed");
  property p_late; $fell(SEL_N_I) && !WR_N_I |-> DATA_OE_N_O [*8]; endproperty
  a_late: assert property (p_late) else $error("drove on late select");
  property p_oe; OE_N_I [*6] |-> DATA_OE_N_O; endproperty
  a_oe: assert property (p_oe) else $error("drove with drive off");
  property p_irq; $fell(FAIL_IRQ_OE_N_O) |-> fcnt_ff >= 600 && fcnt_ff <= 2400; endproperty
  a_irq: assert property (p_irq) else $error("interrupt delay");
  property p_prot; $fell(CPU_RST_OE_N_O) |-> (fcnt_ff >= 9000 && fcnt_ff <= 12500) ##1 RAM_EN_N_O; endproperty
  a_prot: assert property (p_prot) else $error("protect delay");
  property p_hold; $fell(SEL_BLOCKED_O) || $rose(CPU_RST_OE_N_O) |->
    ocnt_ff >= RECOVERY_LEN - 1 && ocnt_ff <= RECOVERY_LEN + 8; endproperty
  a_hold: assert property (p_hold) else $error("recovery length");
  property p_ram; SEL_BLOCKED_O && $past(SEL_BLOCKED_O) |-> RAM_EN_N_O; endproperty
  a_ram: assert property (p_ram) else $error("ram enable leaked");
endmodule
bind pfag_top pfag_assertions #(.RECOVERY_LEN(RECOVERY_LEN)) u_chk (.*);

// >>> test/pfag_bench.sv
// Randomised bench for the power-fail access guard
`timescale 1ns/1ns
module pfag_bench;
  localparam int REC = 50;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pf = 1'b0;
  logic ram_n = 1'b1;
  logic [7:0] rdd_q = 8'h00;
  logic live = 1'b0;
  logic [7:0] rdd = 8'h00;
  logic sel_n, wr_n, oe_n, doe_n, stb, ram_o, irq_oe, rst_oe, blk;
  logic [7:0] din, wdat, rdo;
  int seed = 58;
  int err_total = 0;
  int tests_run = 0;
  int nstb = 0;
  int ndrv = 0;
  int cyc = 0;
  int n;
  int k;
  always #5 clk = ~clk;
  pfag_top #(.RECOVERY_LEN(REC)) u_dut (.CLK_SYS_I(clk), .SRST_I(srst), .POWER_FAIL_I(pf), .SEL_N_I(sel_n),
    .WR_N_I(wr_n), .OE_N_I(oe_n), .RAM_EN_N_I(ram_n), .DATA_I(din), .RD_DATA_I(rdd), .DATA_O(rdo),
    .DATA_OE_N_O(doe_n), .WR_DATA_O(wdat), .WR_STROBE_O(stb), .WR_ACTIVE_O(), .RAM_EN_N_O(ram_o),
    .FAIL_IRQ_N_O(), .FAIL_IRQ_OE_N_O(irq_oe), .CPU_RST_N_O(), .CPU_RST_OE_N_O(rst_oe), .SEL_BLOCKED_O(blk));
  pfag_host_model u_host (.clk_i(clk), .sel_n_o(sel_n), .wr_n_o(wr_n), .oe_n_o(oe_n), .data_o(din));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rdd <= 8'($random(seed));
    if (cyc % 16 == 0) ram_n <= 1'($random(seed));
    if (stb === 1'b1) nstb <= nstb + 1;
    if (doe_n === 1'b0) ndrv <= ndrv + 1;
    rdd_q <= rdd;
  end
  // Read data is the previous cycle's internal word
  always @(negedge clk) if (cyc > 11) chk("rd_data", rdd_q, rdo);
  // Enable held ten cycles, well past the input sync
  always @(negedge clk) if (live && cyc % 16 == 10) chk("ram_en", ram_n, ram_o);
  function automatic logic exp_drive(input int kind, input logic oe, input logic open);
    return kind == 0 && !oe && open;
  endfunction
  function automatic logic probe(input int w);
    case (w)
      0: return irq_oe === 1'b0;
      1: return rst_oe === 1'b0;
      default: return blk === 1'b0;
    endcase
  endfunction
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_rng(input string s, input int lo, input int hi, input int v);
    tests_run++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("[ERR] %s expected %0d..%0d seen %0d", s, lo, hi, v);
    end
  endtask
  task automatic wait_on(input int w, input int lim, output int c);
    c = 0;
    while (!probe(w) && c < lim) begin
      @(posedge clk);
      c++;
    end
    if (c >= lim) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic acc(input int kind, input logic oe, input logic [7:0] d, input logic open);
    int s0;
    int d0;
    s0 = nstb;
    d0 = ndrv;
    u_host.access(kind, oe, d);
    chk("strobes", 8'(open && kind != 0), 8'(nstb - s0));
    if (open && kind != 0) chk("wr_data", d, wdat);
    if (kind != 1) chk("drive", exp_drive(kind, oe, open), ndrv != d0);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("blocked", 1'b1, blk);
    chk("cpu_rst", 1'b0, rst_oe);
    chk("ram_en", 1'b1, ram_o);
    acc(1, 1'b0, 8'hA5, 1'b0);
    wait_on(2, REC + 20, n);
    repeat (2) @(posedge clk);
    chk("cpu_rst", 1'b1, rst_oe);
    live = 1'b1;
    acc(2, 1'b0, 8'h3C, 1'b1);
    acc(0, 1'b1, 8'h00, 1'b1);
    acc(3, 1'b0, 8'h96, 1'b1);
    for (k = 0; k < 12; k++) acc($unsigned($random(seed)) % 3, 1'($random(seed)), 8'($random(seed)), 1'b1);
    // Short dip: neither interrupt nor protection may follow
    pf <= 1'b1;
    repeat (200) @(posedge clk);
    pf <= 1'b0;
    repeat (4) @(posedge clk);
    chk("glitch_irq", 1'b1, irq_oe);
    chk("glitch_prot", 1'b0, blk);
    live = 1'b0;
    pf <= 1'b1;
    wait_on(0, 3000, n);
    chk_rng("irq_delay", 600, 2400, n);
    wait_on(1, 12000, k);
    chk_rng("prot_delay", 9000, 12500, n + k);
    @(posedge clk);
    chk("ram_en", 1'b1, ram_o);
    acc(1, 1'b0, 8'h5A, 1'b0);
    pf <= 1'b0;
    wait_on(2, REC + 20, n);
    chk_rng("recovery", REC, REC + 8, n);
    repeat (2) @(posedge clk);
    live = 1'b1;
    acc(1, 1'b0, 8'hC3, 1'b1);
    wrap_up();
  end
endmodule

// >>> test/pfag_host_model.sv
// Host bus model driving select, strobe, drive and data
`timescale 1ns/1ns
module pfag_host_model (
  input wire logic clk_i,
  output logic sel_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic oe_n_o = 1'b1,
  output logic [7:0] data_o = 8'h00
);
  // Kind 0 read, 1 strobe-ended write, 2 select-ended write, 3 both strobes falling together
  task automatic access(input int kind, input logic oe_n, input logic [7:0] d);
    @(posedge clk_i);
    data_o <= d;
    oe_n_o <= oe_n;
    if (kind >= 2) wr_n_o <= 1'b0;
    if (kind != 2) sel_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    if (kind == 1) wr_n_o <= 1'b0;
    if (kind == 2) sel_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    if (kind == 2) sel_n_o <= 1'b1;
    else wr_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    sel_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    oe_n_o <= 1'b1;
    // Released lines must not keep the old value
    data_o <= ~d;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
